// File: rtl/dbrc_pkg.sv
package dbrc_pkg;
  // Word layout of the serial control word.
  localparam int WORD_W   = 24;
  localparam int ADDR_LSB = 21;
  localparam int ADDR_W   = 3;
  localparam int FREQ_W   = 22;
  localparam int LATCH_W  = 21;
  localparam int CTRL_W   = 13;
  localparam int DEV_LSB  = 13;
  localparam int DEV_W    = 8;
  localparam int DEV_SHL  = 2;
  localparam int SLC_BIT  = 15;
  localparam int MOD_BIT  = 16;
  localparam int DIV_BIT  = 17;
  localparam int ACC_LSB  = 18;
  localparam int ACC_W    = 3;
  localparam int SYNC_N   = 2;
  localparam int FREQ_ADDR_W = 2;

  // Latch addresses in the top bits; frequency words use only two, so bit 21 is data.
  localparam logic [1:0] ADDR_FIRST_FREQ  = 2'h0;
  localparam logic [1:0] ADDR_SECOND_FREQ = 2'h1;
  localparam logic [2:0] ADDR_SECOND_CTRL = 3'h4;
  localparam logic [2:0] ADDR_FIRST_CTRL  = 3'h5;
  localparam logic [2:0] ADDR_TEST        = 3'h7;

  // Values after reset.
  localparam logic [21:0] FREQ_RST  = 22'h000000;
  localparam logic [20:0] LATCH_RST = 21'h000000;

  // Power amplifier mode codes.
  localparam logic [1:0] PA_OFF = 2'h0;

  // Pin order inside the synchroniser vector.
  localparam int PIN_STBY = 0;
  localparam int PIN_BANK = 1;
  localparam int PIN_TX   = 2;
  localparam int PIN_STRB = 3;
  localparam int PIN_N    = 4;

  // Block-enable fields of one bank, bit 12 down to bit 0.
  typedef struct packed {
    logic       synth_en;
    logic       oscillator_en;
    logic [1:0] power_amp_mode;
    logic       slicer_en;
    logic       lowpass_amp_en;
    logic       data_path_switch;
    logic       signal_strength_en;
    logic       limiter_en;
    logic       if_amp_en;
    logic       mixer_en;
    logic [1:0] low_noise_amp_mode;
  } dbrc_bank_t;

  // Decoded block controls of the active bank.
  typedef struct packed {
    logic       lna_en;
    logic       lna_low_gain;
    logic       mixer_en;
    logic       if_amp_en;
    logic       limiter_en;
    logic       signal_strength_en;
    logic       data_path_switch;
    logic       lowpass_amp_en;
    logic       slicer_en;
    logic       demod_en;
    logic       pa_en;
    logic [1:0] power_amp_mode;
    logic       tx_mod_en;
    logic       oscillator_en;
    logic       synth_en;
  } dbrc_rf_t;

  // Shared loop and slicer settings.
  typedef struct packed {
    logic       slicer_learn_select;
    logic [2:0] acquisition_accel_factor;
    logic       loop_divider_select;
    logic       modulation_select;
    logic       test_mode_active;
  } dbrc_misc_t;
endpackage

// File: rtl/dbrc_top.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Low-noise amp code 01 low gain, 11 normal, else off; reset 00.
// - Mixer, IF amp, limiter, strength indicator: one enable bit each.
// - Bit 6 routes lowpass input: 0 demodulator, 1 strength path.
// - Bit 7 enables lowpass amp, bit 8 enables slicer; reset 0.
// - Amp code 00 off, 01 -10 dB, 10 -20 dB, 11 0 dB; nonzero modulates.
// - Bit 12 enables the whole synthesizer loop; reset 0.
// - Demodulator on when limiter, lowpass on and switch at demodulator.
// - First bank frequency word is 22 bits, reset zero.
// - Second bank frequency word is 22 bits, reset zero.
// - Eight-bit deviation in first control word bits 20..13, shared.
// - Second control bit 15: slicer hold 0, learning 1.
// - Second control bits 20..18: three-bit acquisition accel factor.
// - Second control bit 17: loop divider 256 or 512.
// - Active word, plus four times deviation on transmit data when amp code is nonzero, drives frequency.
// - Standby low powers every block down; programming continues.
// - Standby high runs blocks from the active bank; programming continues.
// - Bank-select pin switches banks at once, no reprogramming.
// - Serial bits enter MSB first on rising clock; last 24 kept.
// - Strobe rise loads shift word into the addressed latch.
// - First control word bits 12..0 hold first bank enables.
module dbrc_top (
  // System clock and reset.
  input  wire  logic                sys_clk,
  input  wire  logic                rst_n,
  // Three-wire programming link.
  input  wire  logic                ser_clk,
  input  wire  logic                ser_data,
  input  wire  logic                ser_strobe,
  // Mode pins.
  input  wire  logic                standby_pin,
  input  wire  logic                bank_sel_pin,
  input  wire  logic                tx_data_pin,
  // Block controls.
  output var   dbrc_pkg::dbrc_rf_t   rf_ctrl,
  output var   dbrc_pkg::dbrc_misc_t misc_ctrl,
  output logic [23:0]               freq_word,
  output logic                      active_bank
);
  import dbrc_pkg::*;

  //////////////////////////////////////////////////////////////////
  // Link side.
  //////////////////////////////////////////////////////////////////

  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] shift_nxt;

  // Each rising link clock shifts one bit in at the bottom.
  always_comb begin
    shift_nxt = {shift_r[WORD_W-2:0], ser_data};
  end

  // The word is only data, so it needs no reset.
  always_ff @(posedge ser_clk) begin
    shift_r <= shift_nxt;
  end

  //////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  //////////////////////////////////////////////////////////////////

  logic [PIN_N-1:0] sync_a_r;
  logic [PIN_N-1:0] sync_b_r;
  logic             strobe_d_r;
  logic [PIN_N-1:0] sync_a_nxt;
  logic [PIN_N-1:0] sync_b_nxt;
  logic             strobe_d_nxt;
  logic [PIN_N-1:0] pins;

  assign pins = {ser_strobe, tx_data_pin, bank_sel_pin, standby_pin};

  // Two stages per pin; only the second stage is read.
  always_comb begin
    sync_a_nxt   = pins;
    sync_b_nxt   = sync_a_r;
    strobe_d_nxt = sync_b_r[PIN_STRB];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync_a_r   <= '0;
      sync_b_r   <= '0;
      strobe_d_r <= 1'b0;
    end else begin
      sync_a_r   <= sync_a_nxt;
      sync_b_r   <= sync_b_nxt;
      strobe_d_r <= strobe_d_nxt;
    end
  end

  logic             stby_s;
  logic             bank_s;
  logic             tx_s;
  logic             load;
  logic [ADDR_W-1:0] addr;
  logic [FREQ_ADDR_W-1:0] faddr;

  assign stby_s = sync_b_r[PIN_STBY];
  assign bank_s = sync_b_r[PIN_BANK];
  assign tx_s   = sync_b_r[PIN_TX];
  // The link clock stands still while strobe is high, so the word is
  // stable when the synchronised rising strobe samples it.
  assign load   = sync_b_r[PIN_STRB] & ~strobe_d_r;
  assign addr   = shift_r[ADDR_LSB +: ADDR_W];
  assign faddr  = shift_r[WORD_W-1 -: FREQ_ADDR_W];

  //////////////////////////////////////////////////////////////////
  // Configuration latches.
  //////////////////////////////////////////////////////////////////

  logic [FREQ_W-1:0]  first_freq_r;
  logic [FREQ_W-1:0]  second_freq_r;
  logic [LATCH_W-1:0] first_ctrl_r;
  logic [LATCH_W-1:0] second_ctrl_r;
  logic [LATCH_W-1:0] test_r;
  logic [FREQ_W-1:0]  first_freq_nxt;
  logic [FREQ_W-1:0]  second_freq_nxt;
  logic [LATCH_W-1:0] first_ctrl_nxt;
  logic [LATCH_W-1:0] second_ctrl_nxt;
  logic [LATCH_W-1:0] test_nxt;

  // A strobe writes the addressed latch; other codes are ignored.
  always_comb begin
    first_freq_nxt  = first_freq_r;
    second_freq_nxt = second_freq_r;
    first_ctrl_nxt  = first_ctrl_r;
    second_ctrl_nxt = second_ctrl_r;
    test_nxt        = test_r;
    // Frequency words carry a two-bit address, so bit 21 stays frequency data.
    if (load && faddr == ADDR_FIRST_FREQ) begin
      first_freq_nxt = shift_r[FREQ_W-1:0];
    end else if (load && faddr == ADDR_SECOND_FREQ) begin
      second_freq_nxt = shift_r[FREQ_W-1:0];
    end else if (load) begin
      unique case (addr)
        ADDR_SECOND_CTRL: second_ctrl_nxt = shift_r[LATCH_W-1:0];
        ADDR_FIRST_CTRL:  first_ctrl_nxt  = shift_r[LATCH_W-1:0];
        ADDR_TEST:        test_nxt        = shift_r[LATCH_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      first_freq_r  <= FREQ_RST;
      second_freq_r <= FREQ_RST;
      first_ctrl_r  <= LATCH_RST;
      second_ctrl_r <= LATCH_RST;
      test_r        <= LATCH_RST;
    end else begin
      first_freq_r  <= first_freq_nxt;
      second_freq_r <= second_freq_nxt;
      first_ctrl_r  <= first_ctrl_nxt;
      second_ctrl_r <= second_ctrl_nxt;
      test_r        <= test_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Active bank decode and frequency.
  //////////////////////////////////////////////////////////////////

  dbrc_rf_t   rf_r;
  dbrc_rf_t   rf_nxt;
  dbrc_misc_t misc_r;
  dbrc_misc_t misc_nxt;
  logic [23:0] freq_r;
  logic [23:0] freq_nxt;
  logic        bank_r;
  logic        bank_nxt;
  dbrc_bank_t  bk;
  logic [FREQ_W-1:0] base;
  logic [DEV_W-1:0]  dev;

  assign dev = first_ctrl_r[DEV_LSB +: DEV_W];

  // The synchronised bank pin picks the live bank each cycle.
  always_comb begin
    bank_nxt = bank_s;
    bk   = bank_s ? dbrc_bank_t'(second_ctrl_r[CTRL_W-1:0])
                  : dbrc_bank_t'(first_ctrl_r[CTRL_W-1:0]);
    base = bank_s ? second_freq_r : first_freq_r;
    rf_nxt   = '0;
    freq_nxt = '0;
    // Standby low leaves everything powered down.
    if (stby_s) begin
      rf_nxt.lna_en             = bk.low_noise_amp_mode[0];
      rf_nxt.lna_low_gain       = bk.low_noise_amp_mode == 2'h1;
      rf_nxt.mixer_en           = bk.mixer_en;
      rf_nxt.if_amp_en          = bk.if_amp_en;
      rf_nxt.limiter_en         = bk.limiter_en;
      rf_nxt.signal_strength_en = bk.signal_strength_en;
      rf_nxt.data_path_switch   = bk.data_path_switch;
      rf_nxt.lowpass_amp_en     = bk.lowpass_amp_en;
      rf_nxt.slicer_en          = bk.slicer_en;
      rf_nxt.demod_en           = bk.limiter_en & bk.lowpass_amp_en
                                  & ~bk.data_path_switch;
      rf_nxt.pa_en              = bk.power_amp_mode != PA_OFF;
      rf_nxt.power_amp_mode     = bk.power_amp_mode;
      rf_nxt.tx_mod_en          = bk.power_amp_mode != PA_OFF;
      rf_nxt.oscillator_en      = bk.oscillator_en;
      rf_nxt.synth_en           = bk.synth_en;
      freq_nxt = {2'h0, base};
      if (tx_s && bk.power_amp_mode != PA_OFF) begin
        freq_nxt = 24'({2'h0, base} + (24'(dev) << DEV_SHL));
      end
    end
    misc_nxt.slicer_learn_select      = second_ctrl_r[SLC_BIT];
    misc_nxt.acquisition_accel_factor = second_ctrl_r[ACC_LSB +: ACC_W];
    misc_nxt.loop_divider_select      = second_ctrl_r[DIV_BIT];
    misc_nxt.modulation_select        = second_ctrl_r[MOD_BIT];
    misc_nxt.test_mode_active         = |test_r;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rf_r   <= '0;
      misc_r <= '0;
      freq_r <= '0;
      bank_r <= 1'b0;
    end else begin
      rf_r   <= rf_nxt;
      misc_r <= misc_nxt;
      freq_r <= freq_nxt;
      bank_r <= bank_nxt;
    end
  end

  assign rf_ctrl     = rf_r;
  assign misc_ctrl   = misc_r;
  assign freq_word   = freq_r;
  assign active_bank = bank_r;

  //////////////////////////////////////////////////////////////////
  // Checks.
  //////////////////////////////////////////////////////////////////

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // A pin level held for three cycles reaches the outputs.
  sequence bank_high_s;
    bank_sel_pin [*3];
  endsequence

  sequence bank_low_s;
    !bank_sel_pin [*3];
  endsequence

  sequence stby_low_s;
    !standby_pin [*3];
  endsequence

  // A strobe aimed at the first control word.
  sequence first_ctrl_load_s;
    load && addr == ADDR_FIRST_CTRL;
  endsequence

  bank_switch_a: assert property (bank_high_s |=> active_bank)
    else $error("bank select did not reach the active bank");

  bank_first_a: assert property (bank_low_s |=> !active_bank)
    else $error("bank select low did not reach the active bank");

  standby_down_a: assert property (stby_low_s |=> rf_ctrl == '0
      && freq_word == 24'h000000)
    else $error("blocks not powered down in standby");

  standby_up_a: assert property (stby_s
      |=> rf_ctrl.power_amp_mode == $past(bk.power_amp_mode))
    else $error("amp mode does not follow the bank while operating");

  load_first_a: assert property (load && faddr == ADDR_FIRST_FREQ
      |=> first_freq_r == $past(shift_r[FREQ_W-1:0]))
    else $error("first frequency word not loaded");

  load_second_a: assert property (load && faddr == ADDR_SECOND_FREQ
      |=> second_freq_r == $past(shift_r[FREQ_W-1:0]))
    else $error("second frequency word not loaded");

  load_first_ctrl_a: assert property (first_ctrl_load_s
      |=> first_ctrl_r == $past(shift_r[LATCH_W-1:0]))
    else $error("first control word not loaded");

  load_second_ctrl_a: assert property (load && addr == ADDR_SECOND_CTRL
      |=> second_ctrl_r == $past(shift_r[LATCH_W-1:0]))
    else $error("second control word not loaded");

  load_test_a: assert property (load && addr == ADDR_TEST
      |=> test_r == $past(shift_r[LATCH_W-1:0]))
    else $error("test latch not loaded");

  latch_hold_a: assert property (!load |=> $stable(first_freq_r)
      && $stable(second_freq_r) && $stable(first_ctrl_r)
      && $stable(second_ctrl_r) && $stable(test_r))
    else $error("latch changed without a strobe");

  freq_plain_a: assert property (stby_s && !bank_s && !tx_s
      |=> freq_word == {2'h0, $past(first_freq_r)})
    else $error("frequency does not follow the first bank word");

  freq_second_a: assert property (stby_s && bank_s && !tx_s
      |=> freq_word == {2'h0, $past(second_freq_r)})
    else $error("frequency does not follow the second bank word");

  freq_dev_a: assert property (stby_s && tx_s && rf_nxt.pa_en
      |=> freq_word == 24'({2'h0, $past(base)}
          + {14'h0000, $past(dev), 2'h0}))
    else $error("deviation not added to the frequency");

  demod_auto_a: assert property (rf_ctrl.demod_en
      == (rf_ctrl.limiter_en && rf_ctrl.lowpass_amp_en
          && !rf_ctrl.data_path_switch))
    else $error("demodulator enable wrong");

  pa_modulate_a: assert property (rf_ctrl.tx_mod_en
      == (rf_ctrl.power_amp_mode != PA_OFF))
    else $error("modulation enable does not follow amp code");

  lna_decode_a: assert property (rf_ctrl.lna_low_gain
      |-> rf_ctrl.lna_en)
    else $error("low gain without amplifier enable");

  lna_normal_a: assert property (stby_s && bk.low_noise_amp_mode == 2'h3
      |=> rf_ctrl.lna_en && !rf_ctrl.lna_low_gain)
    else $error("low-noise amp not in normal mode");

  mixer_follow_a: assert property (stby_s
      |=> rf_ctrl.mixer_en == $past(bk.mixer_en))
    else $error("mixer enable does not follow the bank");

  synth_follow_a: assert property (stby_s
      |=> rf_ctrl.synth_en == $past(bk.synth_en))
    else $error("synthesizer enable does not follow the bank");

  accel_follow_a: assert property (misc_ctrl.acquisition_accel_factor
      == $past(second_ctrl_r[ACC_LSB +: ACC_W]))
    else $error("acceleration factor does not follow the latch");

  divider_follow_a: assert property (misc_ctrl.loop_divider_select
      == $past(second_ctrl_r[DIV_BIT]))
    else $error("loop divider does not follow the latch");

  slicer_load_a: assert property (load && addr == ADDR_SECOND_CTRL
      |=> ##1 misc_ctrl.slicer_learn_select
          == $past(shift_r[SLC_BIT], 2))
    else $error("slicer mode not loaded");

endmodule

`default_nettype wire

// File: test/dbrc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Microcontroller side of the three-wire link; the link clock rests low between words.
module dbrc_host_model (
  // Three-wire programming link.
  output var logic ser_clk,
  output var logic ser_data,
  output var logic ser_strobe
);
  initial begin
    ser_clk    = 1'b0;
    ser_data   = 1'b0;
    ser_strobe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shifts 28 bits MSB first, so four leading bits must fall off the top.
  task automatic send(input logic [27:0] v);
    for (int i = 27; i >= 0; i--) begin
      ser_data = v[i];
      #8;
      ser_clk = 1'b1;
      #16;
      ser_clk = 1'b0;
      #8;
    end
    // Clock and data stay low around the whole strobe pulse.
    ser_data = 1'b0;
    #8;
    ser_strobe = 1'b1;
    #30;
    ser_strobe = 1'b0;
    #30;
  endtask
endmodule

`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import dbrc_pkg::*;

  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        standby_pin = 1'b0;
  logic        bank_sel_pin = 1'b0;
  logic        tx_data_pin = 1'b0;
  wire         ser_clk;
  wire         ser_data;
  wire         ser_strobe;
  dbrc_rf_t    rf_ctrl;
  dbrc_misc_t  misc_ctrl;
  logic [23:0] freq_word;
  logic        active_bank;
  logic [23:0] a_w = '0, b_w = '0, c_w = '0, d_w = '0, e_w = '0;
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;

  dbrc_host_model host (.ser_clk(ser_clk), .ser_data(ser_data), .ser_strobe(ser_strobe));

  dbrc_top DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_strobe(ser_strobe), .standby_pin(standby_pin), .bank_sel_pin(bank_sel_pin),
    .tx_data_pin(tx_data_pin), .rf_ctrl(rf_ctrl), .misc_ctrl(misc_ctrl),
    .freq_word(freq_word), .active_bank(active_bank)
  );

  // The system clock runs at 200 MHz.
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A hung run is cut short well beyond the expected length.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      conclude();
    end
  end

  task automatic cmp(input string nm, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Sends one word with four junk leading bits and mirrors the addressed latch.
  task automatic wr(input logic [23:0] w);
    host.send({4'hB, w});
    // Frequency words are told apart by their two top bits alone.
    if (w[23:22] == ADDR_FIRST_FREQ) a_w = w;
    else if (w[23:22] == ADDR_SECOND_FREQ) b_w = w;
    else if (w[23:21] == ADDR_SECOND_CTRL) c_w = w;
    else if (w[23:21] == ADDR_FIRST_CTRL) d_w = w;
    else if (w[23:21] == ADDR_TEST) e_w = w;
    repeat (3) @(posedge sys_clk);
  endtask

  // Moves the mode pins and waits out the synchroniser and output stage.
  task automatic pins(input logic s, input logic b, input logic t);
    @(posedge sys_clk);
    standby_pin  <= s;
    bank_sel_pin <= b;
    tx_data_pin  <= t;
    repeat (5) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Works out every output from the mirrored latches and the pins.
  task automatic check_all();
    dbrc_bank_t  bk;
    dbrc_rf_t    er;
    logic [23:0] ef;
    #1;
    bk = bank_sel_pin ? c_w[12:0] : d_w[12:0];
    er = '{bk.low_noise_amp_mode[0], bk.low_noise_amp_mode == 2'h1, bk.mixer_en, bk.if_amp_en,
           bk.limiter_en, bk.signal_strength_en, bk.data_path_switch, bk.lowpass_amp_en,
           bk.slicer_en, bk.limiter_en & bk.lowpass_amp_en & ~bk.data_path_switch,
           |bk.power_amp_mode, bk.power_amp_mode, |bk.power_amp_mode, bk.oscillator_en,
           bk.synth_en};
    ef = {2'h0, bank_sel_pin ? b_w[21:0] : a_w[21:0]};
    if (tx_data_pin && bk.power_amp_mode != PA_OFF) ef = ef + {14'h0, d_w[20:13], 2'h0};
    if (!standby_pin) begin
      er = '0;
      ef = '0;
    end
    cmp("rf_ctrl", {8'h0, er}, {8'h0, rf_ctrl});
    cmp("freq_word", ef, freq_word);
    cmp("misc_ctrl", {17'h0, c_w[15], c_w[20:18], c_w[17], c_w[16], |e_w[20:0]},
        {17'h0, misc_ctrl});
    cmp("active_bank", {23'h0, bank_sel_pin}, {23'h0, active_bank});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence of scenarios.
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check_all();
    wr({ADDR_TEST, 21'h000000});
    wr({ADDR_TEST, 21'h000001});
    check_all();
    wr({ADDR_TEST, 21'h000000});
    check_all();
    // Programming in standby, with the oscillator bit set and modulation select left at 0.
    wr({ADDR_FIRST_FREQ, 22'h212345});
    wr({ADDR_SECOND_FREQ, 22'h30ABCD});
    wr({ADDR_FIRST_CTRL, 8'h5A, 13'h1BBF});
    wr({ADDR_SECOND_CTRL, 8'hB4, 13'h1CF5});
    check_all();
    pins(1'b1, 1'b0, 1'b0);
    check_all();
    pins(1'b1, 1'b0, 1'b1);
    check_all();
    pins(1'b1, 1'b1, 1'b1);
    check_all();
    // Every amplifier code, both data switch settings and several loop settings.
    for (int i = 0; i < 4; i++) begin
      wr({ADDR_SECOND_CTRL, i[2:0], i[0], 1'b0, ~i[0], 2'h0,
          2'h3, i[1:0], 1'b1, 1'b1, i[0], 3'h2, 1'b1, i[1:0]});
      check_all();
    end
    // A word to an unmapped address changes nothing.
    wr({3'h6, 21'h1FFFFF});
    check_all();
    pins(1'b0, 1'b1, 1'b1);
    check_all();
    conclude();
  end
endmodule

`default_nettype wire
